// ---- rtl/nvp_credit_port.sv ----
// How it works
// RULE1 - A recognised note pulls its channel's credit line low for one 100 ms pulse, within 3 ms.
// RULE2 - There is one credit line for each of the first four channels and no more.
// RULE3 - The host throws away any credit pulse whose width lies outside 100 ms plus or minus 3 ms.
// RULE4 - Acceptance inputs idle high, and a low input enables its channel while high inhibits it.
// RULE5 - With no acceptance input low the port is globally disabled and refuses every note.
// RULE6 - The busy line is low while a note is being processed and high otherwise.
// RULE7 - With low power set the port sleeps about 6 s after reset until a note is inserted.
// RULE8 - With low power set the port sleeps again about 1 s after a credit or a rejection.
// RULE9 - One validated note is held in escrow and stacked only once the host confirms the vend.
// RULE10 - All credit lines stay high when idle and at most one pulse is ever active.
// RULE11 - Acceptance inputs are sampled before a note is taken, and an inhibited channel rejects.
//
// Chosen here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module nvp_credit_port
  import nvp_pkg::*;
#(
  parameter int unsigned TICK_CYC = nvp_pkg::TICK_CYCLES
) (
  // Clock, reset and clock enable.
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [1:0] hresp,
  output logic [31:0] hrdata,
  // Host side pins.
  input wire logic [nvp_pkg::NCHAN-1:0] accept_n,
  input wire logic escrow_ok_n,
  output logic [nvp_pkg::NCHAN-1:0] credit_n,
  output logic busy_n,
  // Mechanism side.
  output logic low_power,
  output logic note_stack,
  output logic note_return
);
  import nvp_pkg::*;

  nvp_state_type state_reg, state_next;
  nvp_ctrl_type ctrl_reg;
  logic [MS_W-1:0] ms_reg, ms_next;
  logic [CH_W-1:0] chan_reg;
  logic wr_pend_reg;
  logic [DEC_W-1:0] wr_addr_reg;
  logic last_accept_reg, last_reject_reg, refused_reg;
  logic tick;

  // Bus decode.
  wire take = hsel && htrans[1] && hready;
  wire [DEC_W-1:0] a_dec = haddr[DEC_W-1:0];
  wire in_range = (haddr[31:DEC_W] == '0);
  wire rd_ctrl = take && !hwrite && in_range && (a_dec == OFF_CTRL);
  wire rd_status = take && !hwrite && in_range && (a_dec == OFF_STATUS);
  wire wr_ctrl = wr_pend_reg && (wr_addr_reg == OFF_CTRL);
  wire wr_note = wr_pend_reg && (wr_addr_reg == OFF_NOTE);
  wire wr_status = wr_pend_reg && (wr_addr_reg == OFF_STATUS);
  wire go = wr_note && hwdata[NOTE_GO_BIT];
  wire [CH_W-1:0] go_chan = hwdata[NOTE_CH_LSB +: CH_W];

  // A new note may enter only while nothing is in the path.
  wire can_take = (state_reg == ST_IDLE) || (state_reg == ST_SLEEP) || (state_reg == ST_TRAIL);
  wire start = go && can_take;
  wire refuse_evt = go && !can_take;
  wire global_disable = &accept_n; // [RULE5]
  wire chan_enabled = !accept_n[chan_reg] && !global_disable; // [RULE4] [RULE11]
  wire ms_done = (ms_reg == MS_ZERO);
  wire ms_last = (ms_reg == MS_ONE) && tick;
  wire busy_now = (state_next == ST_CHECK) || (state_next == ST_CREDIT) ||
    (state_next == ST_ESCROW) || (state_next == ST_STACK) || (state_next == ST_REJECT);
  wire restart_tick = start || (state_reg == ST_CHECK) || (state_reg == ST_STACK) ||
    (state_reg == ST_REJECT);

  nvp_status_type status;
  assign status = '{
    refused: refused_reg,
    last_reject: last_reject_reg,
    last_accept: last_accept_reg,
    global_disable: global_disable,
    low_power: low_power,
    busy: !busy_n,
    state: state_reg
  };
  wire [31:0] rd_word = rd_ctrl ? {30'h0000_0000, ctrl_reg} :
    rd_status ? {23'h00_0000, status} : WORD_ZERO;

  nvp_tick #(
    .CYCLES(TICK_CYC)
  ) u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .restart(restart_tick),
    .tick(tick)
  );

  // Note path sequencing.
  always_comb begin
    state_next = state_reg;
    ms_next = (tick && !ms_done) ? ms_reg - MS_ONE : ms_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = ST_CHECK;
        end else if (ms_done && ctrl_reg.low_power_en) begin
          state_next = ST_SLEEP; // [RULE7]
        end
      end
      ST_SLEEP: begin
        if (start) begin
          state_next = ST_CHECK; // [RULE7]
        end
      end
      ST_CHECK: begin
        if (chan_enabled) begin
          state_next = ST_CREDIT; // [RULE11]
          ms_next = CREDIT_CNT; // [RULE1]
        end else begin
          state_next = ST_REJECT; // [RULE11] [RULE5]
        end
      end
      ST_CREDIT: begin
        if (ms_last) begin
          state_next = ctrl_reg.escrow_en ? ST_ESCROW : ST_STACK; // [RULE1]
        end
      end
      ST_ESCROW: begin
        if (!escrow_ok_n) begin
          state_next = ST_STACK; // [RULE9]
        end
      end
      ST_STACK: begin
        state_next = ST_TRAIL;
        ms_next = RETURN_CNT; // [RULE8]
      end
      ST_REJECT: begin
        state_next = ST_TRAIL;
        ms_next = RETURN_CNT; // [RULE8]
      end
      ST_TRAIL: begin
        if (start) begin
          state_next = ST_CHECK;
        end else if (ms_done || ms_last) begin
          state_next = ctrl_reg.low_power_en ? ST_SLEEP : ST_IDLE; // [RULE8]
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_IDLE;
      ms_reg <= POWERUP_CNT; // [RULE7]
      chan_reg <= '0;
    end else if (ce) begin
      state_reg <= state_next;
      ms_reg <= ms_next;
      if (start) begin
        chan_reg <= go_chan; // [RULE2]
      end
    end
  end

  // Pins, all registered; the credit lines follow the next state so they switch with it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      credit_n <= '1; // [RULE10]
      busy_n <= 1'b1;
      low_power <= 1'b0;
      note_stack <= 1'b0;
      note_return <= 1'b0;
    end else if (ce) begin
      for (int i = 0; i < NCHAN; i++) begin
        credit_n[i] <= !((state_next == ST_CREDIT) && (chan_reg == CH_W'(i))); // [RULE1] [RULE10]
      end
      busy_n <= !busy_now; // [RULE6]
      low_power <= (state_next == ST_SLEEP); // [RULE7] [RULE8]
      note_stack <= (state_next == ST_STACK); // [RULE9]
      note_return <= (state_next == ST_REJECT);
    end
  end

  // Outcome flags; the refused flag is write-one-to-clear and a new event beats the clear.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_accept_reg <= 1'b0;
      last_reject_reg <= 1'b0;
      refused_reg <= 1'b0;
      ctrl_reg <= CTRL_RESET;
    end else if (ce) begin
      if (start) begin
        last_accept_reg <= 1'b0;
        last_reject_reg <= 1'b0;
      end else if (state_reg == ST_STACK) begin
        last_accept_reg <= 1'b1;
      end else if (state_reg == ST_REJECT) begin
        last_reject_reg <= 1'b1;
      end
      if (refuse_evt) begin
        refused_reg <= 1'b1;
      end else if (wr_status && hwdata[STAT_REFUSED_BIT]) begin
        refused_reg <= 1'b0;
      end
      if (wr_ctrl) begin
        ctrl_reg.low_power_en <= hwdata[CTRL_LP_BIT];
        ctrl_reg.escrow_en <= hwdata[CTRL_ESC_BIT];
      end
    end
  end

  // Zero-wait slave: read data is captured in the address phase, writes land in the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      hrdata <= WORD_ZERO;
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end else if (ce) begin
      wr_pend_reg <= take && hwrite && in_range;
      wr_addr_reg <= a_dec;
      hrdata <= rd_word;
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end
  end
endmodule : nvp_credit_port
`default_nettype wire

// ---- rtl/nvp_pkg.sv ----
package nvp_pkg;
  // Clock and time base.
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYCLES = TICK_US * CLK_MHZ;
  // Durations counted in 1 ms ticks.
  localparam int unsigned CREDIT_MS = 100;
  localparam int unsigned CREDIT_TOL_MS = 3;
  localparam int unsigned POWERUP_MS = 6000;
  localparam int unsigned RETURN_MS = 1000;
  localparam int unsigned MS_W = 13;
  localparam logic [MS_W-1:0] CREDIT_CNT = MS_W'(CREDIT_MS);
  localparam logic [MS_W-1:0] POWERUP_CNT = MS_W'(POWERUP_MS);
  localparam logic [MS_W-1:0] RETURN_CNT = MS_W'(RETURN_MS);
  localparam logic [MS_W-1:0] MS_ZERO = 13'h0000;
  localparam logic [MS_W-1:0] MS_ONE = 13'h0001;
  // Port widths.
  localparam int unsigned NCHAN = 4;
  localparam int unsigned CH_W = 2;
  // Register byte addresses.
  localparam int unsigned DEC_W = 12;
  localparam logic [DEC_W-1:0] OFF_CTRL = 12'h000;
  localparam logic [DEC_W-1:0] OFF_NOTE = 12'h004;
  localparam logic [DEC_W-1:0] OFF_STATUS = 12'h008;
  // Field positions.
  localparam int unsigned CTRL_LP_BIT = 0;
  localparam int unsigned CTRL_ESC_BIT = 1;
  localparam int unsigned NOTE_CH_LSB = 0;
  localparam int unsigned NOTE_GO_BIT = 2;
  localparam int unsigned STAT_REFUSED_BIT = 8;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [1:0] HRESP_OKAY = 2'h0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SLEEP = 3'b001,
    ST_CHECK = 3'b010,
    ST_CREDIT = 3'b011,
    ST_ESCROW = 3'b100,
    ST_STACK = 3'b101,
    ST_REJECT = 3'b110,
    ST_TRAIL = 3'b111
  } nvp_state_type;

  // Status word, packed from bit 8 down to bit 0.
  typedef struct packed {
    logic refused;
    logic last_reject;
    logic last_accept;
    logic global_disable;
    logic low_power;
    logic busy;
    nvp_state_type state;
  } nvp_status_type;

  typedef struct packed {
    logic escrow_en;
    logic low_power_en;
  } nvp_ctrl_type;
endpackage : nvp_pkg

// ---- rtl/nvp_tick.sv ----
`timescale 1ns/1ps
`default_nettype none
module nvp_tick #(
  parameter int unsigned CYCLES = 100000
) (
  // Clock, reset and clock enable.
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Control and output.
  input wire logic restart,
  output logic tick
);
  localparam int unsigned W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);
  logic [W-1:0] cnt_reg;
  wire at_last = (cnt_reg == LAST);

  // Restart lines the first tick up exactly one period after the request.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= '0;
      tick <= 1'b0;
    end else if (ce) begin
      cnt_reg <= (restart || at_last) ? '0 : cnt_reg + 1'b1;
      tick <= at_last && !restart;
    end
  end
endmodule : nvp_tick
`default_nettype wire

// ---- tb/nvp_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module nvp_host
  import nvp_pkg::*;
#(
  parameter int unsigned TICK_CYC = 100000
) (
  // Clock, reset and bench control.
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [3:0] en_mask,
  input wire logic vend_done,
  // Device pins and credit tallies.
  input wire logic [3:0] credit_n,
  output logic [3:0] accept_n,
  output logic escrow_ok_n,
  output logic [3:0][7:0] good,
  output logic [7:0] bad
);
  localparam int LO = (CREDIT_MS - CREDIT_TOL_MS) * TICK_CYC;
  localparam int HI = (CREDIT_MS + CREDIT_TOL_MS) * TICK_CYC;
  int w [4];
  // A channel not held low floats to the pull-up level and is inhibited.
  assign accept_n = ~en_mask;
  assign escrow_ok_n = ~vend_done;
  always @(posedge hclk or negedge hresetn) begin
    for (int i = 0; i < 4; i++) begin
      if (!hresetn) begin
        w[i] <= 0;
        good[i] <= 8'h00;
      end else if (credit_n[i] === 1'b0) begin
        w[i] <= w[i] + 1;
      end else if (w[i] != 0) begin
        w[i] <= 0;
        // Noise can fake a credit, so only in-window widths count.
        if (w[i] >= LO && w[i] <= HI) good[i] <= good[i] + 8'h01;
        else bad <= bad + 8'h01;
      end
    end
    if (!hresetn) bad <= 8'h00;
  end
endmodule : nvp_host
`default_nettype wire

// ---- tb/nvp_credit_port_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module nvp_chk
  import nvp_pkg::*;
#(
  parameter int unsigned TICK_CYC = 100000
) (
  // Watched ports.
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [3:0] accept_n,
  input wire logic [3:0] credit_n,
  input wire logic busy_n,
  input wire logic low_power,
  input wire logic note_stack,
  input wire logic note_return
);
  localparam int PW = CREDIT_MS * TICK_CYC;
  logic [31:0] w_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) w_reg <= 32'h0;
    else w_reg <= (credit_n != 4'hf) ? w_reg + 32'h1 : 32'h0;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_start;
    credit_n != 4'hf && $past(credit_n) == 4'hf;
  endsequence
  sequence s_end;
    credit_n == 4'hf && $past(credit_n) != 4'hf;
  endsequence
  property p_width;
    s_end |-> w_reg >= PW - 2 && w_reg <= PW + 2;
  endproperty
  a_width: assert property (p_width) else $error("credit width wrong");
  property p_one;
    $onehot0(~credit_n);
  endproperty
  a_one: assert property (p_one) else $error("two credits");
  property p_busy;
    credit_n != 4'hf |-> !busy_n;
  endproperty
  a_busy: assert property (p_busy) else $error("busy high in credit");
  property p_stack;
    note_stack |=> busy_n && !note_stack;
  endproperty
  a_stack: assert property (p_stack) else $error("stack pulse wrong");
  property p_ret;
    note_return |-> credit_n == 4'hf ##[1:2] busy_n;
  endproperty
  a_ret: assert property (p_ret) else $error("reject wrong");
  property p_acc;
    s_start |-> (~credit_n & $past(accept_n)) == 4'h0;
  endproperty
  a_acc: assert property (p_acc) else $error("credit on inhibited");
  property p_gd;
    (&accept_n) && credit_n == 4'hf |=> credit_n == 4'hf;
  endproperty
  a_gd: assert property (p_gd) else $error("credit while disabled");
  property p_lp;
    low_power |-> busy_n && credit_n == 4'hf;
  endproperty
  a_lp: assert property (p_lp) else $error("sleep while busy");
endmodule : nvp_chk
bind nvp_credit_port nvp_chk #(.TICK_CYC(TICK_CYC)) u_chk (.hclk, .hresetn, .accept_n,
  .credit_n, .busy_n, .low_power, .note_stack, .note_return);
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import nvp_pkg::*;
  localparam int T = 2;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, vend_done = 1'b0;
  logic ce = 1'b1;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [3:0] en_mask = 4'h0;
  logic hreadyout, busy_n, low_power, note_stack, note_return, escrow_ok_n;
  logic [1:0] hresp;
  logic [31:0] hrdata;
  logic [3:0] accept_n, credit_n;
  logic [3:0][7:0] good;
  logic [7:0] bad;
  int fail_count = 0, tests_run = 0, n, stacks = 0, rets = 0;
  always #5 hclk = ~hclk;
  always @(posedge hclk) begin
    if (note_stack === 1'b1) stacks++;
    if (note_return === 1'b1) rets++;
  end
  nvp_credit_port #(.TICK_CYC(T)) dut (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .accept_n, .escrow_ok_n, .credit_n, .busy_n, .low_power, .note_stack, .note_return);
  nvp_host #(.TICK_CYC(T)) host (.hclk, .hresetn, .en_mask, .vend_done, .credit_n,
    .accept_n, .escrow_ok_n, .good, .bad);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  task automatic wait_for(input int sel, input int lim);
    for (n = 0; n < lim; n++) begin
      @(posedge hclk);
      if ((sel == 0 && busy_n === 1'b1) || (sel == 1 && low_power === 1'b1)) break;
      if (sel == 2 && good[3] !== 8'h00) break;
      if (sel == 3 && hreadyout === 1'b1) break;
    end
    if (n >= lim) begin
      fail_count++;
      wrap_up();
    end
  endtask : wait_for
  // Address phase is held until hready, then data phase until hready again.
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_for(3, 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_for(3, 50);
    rd = hrdata;
    check("hresp", hresp, HRESP_OKAY);
  endtask : bus
  task automatic t_reset();
    check("credit idle", credit_n, 4'hf);
    check("busy idle", busy_n, 1'b1);
    bus(1'b0, OFF_STATUS, 32'h0);
    check("status", rd, 32'h20);
    bus(1'b0, 32'h100, 32'h0);
    check("unmapped", rd, 32'h0);
    // A frozen port must ignore a write that arrives while the enable is low.
    ce <= 1'b0;
    bus(1'b1, OFF_CTRL, 32'h3);
    ce <= 1'b1;
    bus(1'b0, OFF_CTRL, 32'h0);
    check("frozen write", rd, 32'h0);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_lp();
    bus(1'b1, OFF_CTRL, 32'h1);
    wait_for(1, POWERUP_MS * T + 100);
    check("sleep time", n > POWERUP_MS * T - 40, 1'b1);
    en_mask <= 4'h4;
    bus(1'b1, OFF_NOTE, 32'h6);
    @(posedge hclk);
    check("woken", low_power, 1'b0);
    wait_for(0, 400 * T);
    check("credit ch2", good[2], 8'h01);
    check("stacked", stacks, 1);
    wait_for(1, RETURN_MS * T + 50);
    check("return time", n > RETURN_MS * T - 20, 1'b1);
    $display("t_lp done");
  endtask : t_lp
  task automatic t_reject(input logic [3:0] m, input int r);
    en_mask <= m;
    bus(1'b1, OFF_NOTE, 32'h5);
    wait_for(0, 50);
    check("returned", rets, r);
    bus(1'b0, OFF_STATUS, 32'h0);
    check("last reject", rd[7], 1'b1);
    check("disable flag", rd[5], m == 4'h0);
    $display("t_reject done");
  endtask : t_reject
  task automatic t_refuse();
    en_mask <= 4'h1;
    bus(1'b1, OFF_NOTE, 32'h4);
    bus(1'b1, OFF_NOTE, 32'h4);
    bus(1'b0, OFF_STATUS, 32'h0);
    check("refused", rd[8], 1'b1);
    bus(1'b1, OFF_STATUS, 32'h100);
    bus(1'b0, OFF_STATUS, 32'h0);
    check("refused clear", rd[8], 1'b0);
    wait_for(0, 400 * T);
    check("single credit", good[0], 8'h01);
    $display("t_refuse done");
  endtask : t_refuse
  task automatic t_escrow();
    bus(1'b1, OFF_CTRL, 32'h2);
    en_mask <= 4'h8;
    bus(1'b1, OFF_NOTE, 32'h7);
    wait_for(2, 400 * T);
    repeat (20) @(posedge hclk);
    check("held", stacks, 2);
    check("busy held", busy_n, 1'b0);
    vend_done <= 1'b1;
    wait_for(0, 50);
    vend_done <= 1'b0;
    check("stack after vend", stacks, 3);
    $display("t_escrow done");
  endtask : t_escrow
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_lp();
    t_reject(4'h1, 1);
    t_refuse();
    t_reject(4'h0, 2);
    t_escrow();
    check("bad pulses", bad, 8'h00);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
